// file: logic/atsi_pkg.sv
// Constants and carrier types for the asynchronous timer 0 block.
package atsi_pkg;

   // ********************************************************************
   // Register byte offsets
   // ********************************************************************
   localparam logic [11:0] ATSI_OFF_COUNT = 12'h000;
   localparam logic [11:0] ATSI_OFF_COMPARE = 12'h004;
   localparam logic [11:0] ATSI_OFF_CONTROL = 12'h008;
   localparam logic [11:0] ATSI_OFF_ASYNC_STATUS = 12'h00C;
   localparam logic [11:0] ATSI_OFF_IRQ_MASK = 12'h010;
   localparam logic [11:0] ATSI_OFF_IRQ_FLAG = 12'h014;

   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int ATSI_ASYNC_SEL_BIT = 3;
   localparam int ATSI_CMP_IE_BIT = 1;
   localparam int ATSI_OVF_IE_BIT = 0;
   localparam int ATSI_CMP_FLAG_BIT = 1;
   localparam int ATSI_OVF_FLAG_BIT = 0;

   // ********************************************************************
   // Reset values and fixed values
   // ********************************************************************
   localparam logic [7:0] ATSI_RST_BYTE = 8'h00;
   localparam logic [7:0] ATSI_COUNT_MAX = 8'hFF;
   localparam logic [7:0] ATSI_CTRL_RUN_MASK = 8'h07;
   localparam logic [31:0] ATSI_RD_ZERO = 32'h0000_0000;

   // Busy bits in the same order as the async status register, bit 2 down to 0.
   typedef struct packed {
      logic cnt;
      logic cmp;
      logic ctrl;
   } atsi_busy_t;

   // Flags in the same order as the interrupt flag register, bit 1 down to 0.
   typedef struct packed {
      logic cmp;
      logic ovf;
   } atsi_flags_t;

endpackage : atsi_pkg

// file: logic/atsi_top.sv
// Timer 0 counter, compare and asynchronous update logic with an APB register slave.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - A count write suppresses the compare match on the next timer tick.
// - An 8-bit compare value is checked against the count on every tick.
// - Async select low runs from pclk; high runs from the oscillator pin.
// - Async count write sets count busy; cleared after transfer into counter.
// - Async compare write sets compare busy; cleared after transfer.
// - Async control write sets control busy; cleared after transfer.
// - Count reads the timer value; compare and control read their temporaries.
// - Async writes go to a temporary, latched after two oscillator rising edges.
// - Each async register has its own temporary and transfer tracking.
// - Compare match is disabled while compare or count transfer is pending.
// - In power-save with async select high, wake-up starts on the timer tick after the event.
// - Count is read through a holding register refreshed every pclk in sync mode and one cycle after each oscillator rise in async mode.
// - Async flag sync takes one timer cycle plus three pclk cycles.
// - Compare output pin changes on the timer tick, not resynchronised.
// - Compare irq needs compare enable, global enable and compare flag.
// - Compare flag sets on match; cleared by vector ack or writing one.
// - Overflow flag sets on overflow; cleared by vector ack or writing one.
// - Overflow irq needs overflow enable, global enable and overflow flag.
module atsi_top
   import atsi_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_input_pin,
   input wire logic cpu_irq_enable,
   input wire logic power_save_sleep,
   input wire logic compare_vector_ack,
   input wire logic overflow_vector_ack,
   output logic compare_irq,
   output logic overflow_irq,
   output logic compare_output_pin,
   output logic wake_req
);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ********************************************************************
   // APB slave
   // ********************************************************************
   logic access;
   logic wr;
   logic [ADDR_W-1:0] off;
   logic hit;
   logic [31:0] rd_nxt;
   logic [7:0] wbyte;
   logic [7:0] count_r;
   logic [7:0] count_hold_r;
   logic [7:0] compare_r;
   logic [7:0] compare_tmp_r;
   logic [7:0] count_tmp_r;
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_tmp_r;
   logic [7:0] irq_mask_r;
   logic async_sel_r;
   atsi_busy_t busy_r;
   atsi_flags_t flag_r;

   assign access = psel & penable & pready;
   assign wr = access & pwrite;
   assign off = paddr;
   assign wbyte = pwdata[7:0];

   always_comb
   begin
      hit = 1'b1;
      rd_nxt = ATSI_RD_ZERO;
      case (off)
         ATSI_OFF_COUNT: rd_nxt[7:0] = count_hold_r;
         ATSI_OFF_COMPARE: rd_nxt[7:0] = compare_tmp_r;
         ATSI_OFF_CONTROL: rd_nxt[7:0] = ctrl_tmp_r;
         ATSI_OFF_ASYNC_STATUS: rd_nxt[7:0] = {4'h0, async_sel_r, busy_r};
         ATSI_OFF_IRQ_MASK: rd_nxt[7:0] = irq_mask_r;
         ATSI_OFF_IRQ_FLAG: rd_nxt[7:0] = {6'h00, flag_r};
         default: hit = 1'b0;
      endcase
   end

   // Zero-wait slave: the answer is prepared in the setup cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= ATSI_RD_ZERO;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         if (psel & ~penable)
         begin
            prdata <= pwrite ? ATSI_RD_ZERO : rd_nxt;
            pslverr <= ~hit;
         end
      end
   end

   logic wr_cnt;
   logic wr_cmp;
   logic wr_ctrl;
   logic wr_flag;
   assign wr_cnt = wr & (off == ATSI_OFF_COUNT);
   assign wr_cmp = wr & (off == ATSI_OFF_COMPARE);
   assign wr_ctrl = wr & (off == ATSI_OFF_CONTROL);
   assign wr_flag = wr & (off == ATSI_OFF_IRQ_FLAG);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         async_sel_r <= 1'b0;
         irq_mask_r <= ATSI_RST_BYTE;
      end
      else
      begin
         if (wr & (off == ATSI_OFF_ASYNC_STATUS))
            async_sel_r <= wbyte[ATSI_ASYNC_SEL_BIT];
         if (wr & (off == ATSI_OFF_IRQ_MASK))
            irq_mask_r <= wbyte;
      end
   end

   // ********************************************************************
   // Oscillator pin sampling
   // ********************************************************************
   // The pin is asynchronous to pclk; the crystal must run below a quarter
   // of pclk so that no rising edge is lost.
   logic osc_s1_r;
   logic osc_s2_r;
   logic osc_s3_r;
   logic osc_lvl_r;
   logic osc_rise;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
         osc_lvl_r <= 1'b0;
      end
      else
      begin
         osc_s1_r <= osc_input_pin;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
         if (osc_s2_r == osc_s3_r)
            osc_lvl_r <= osc_s3_r;
      end
   end

   assign osc_rise = (osc_s2_r == osc_s3_r) & osc_s3_r & ~osc_lvl_r;

   // ********************************************************************
   // Temporary registers and transfers
   // ********************************************************************
   atsi_busy_t wr_async;
   atsi_busy_t pend_r;
   atsi_busy_t edge1_r;
   atsi_busy_t xfer;
   atsi_busy_t bsy_s1_r;
   atsi_busy_t bsy_s2_r;

   assign wr_async = {wr_cnt, wr_cmp, wr_ctrl} & {3{async_sel_r}};
   assign xfer = pend_r & edge1_r & {3{osc_rise}};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend_r <= '0;
         edge1_r <= '0;
      end
      else
      begin
         pend_r <= (pend_r & ~xfer) | wr_async;
         edge1_r <= (edge1_r | (pend_r & {3{osc_rise}})) & ~xfer & ~wr_async;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bsy_s1_r <= '0;
         bsy_s2_r <= '0;
      end
      else
      begin
         bsy_s1_r <= xfer;
         bsy_s2_r <= bsy_s1_r;
      end
   end

   // Busy flags, set wins over clear.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         busy_r <= '0;
      else
         busy_r <= (busy_r & ~bsy_s2_r) | wr_async;
   end

   chk_busy_set_write: assert property (wr_async.cnt |=> busy_r.cnt)
      else $error("count busy not set by async write");
   chk_cmp_busy_set: assert property (wr_async.cmp |=> busy_r.cmp)
      else $error("compare busy not set by async write");
   chk_ctrl_busy_clr: assert property (xfer.ctrl && !wr_async.ctrl ##1 !wr_async.ctrl ##1 !wr_async.ctrl
      |=> !busy_r.ctrl)
      else $error("control busy not cleared after transfer");

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         compare_tmp_r <= ATSI_RST_BYTE;
         count_tmp_r <= ATSI_RST_BYTE;
         ctrl_tmp_r <= ATSI_RST_BYTE;
         compare_r <= ATSI_RST_BYTE;
         ctrl_r <= ATSI_RST_BYTE;
      end
      else
      begin
         if (wr_cmp)
            compare_tmp_r <= wbyte;
         if (wr_cnt)
            count_tmp_r <= wbyte;
         if (wr_ctrl)
            ctrl_tmp_r <= wbyte;
         if (wr_cmp & ~async_sel_r)
            compare_r <= wbyte;
         else if (xfer.cmp)
            compare_r <= compare_tmp_r;
         if (wr_ctrl & ~async_sel_r)
            ctrl_r <= wbyte;
         else if (xfer.ctrl)
            ctrl_r <= ctrl_tmp_r;
      end
   end

   chk_tmp_latch: assert property (xfer.cmp && !wr_cmp |=> compare_r == $past(compare_tmp_r))
      else $error("compare temporary not latched at transfer");

   // ********************************************************************
   // Counter and compare
   // ********************************************************************
   logic run;
   logic tick;
   logic block_r;
   logic cmp_event;
   logic ovf_event;

   assign run = (ctrl_r & ATSI_CTRL_RUN_MASK) != ATSI_RST_BYTE;
   assign tick = run & (async_sel_r ? osc_rise : 1'b1);
   // Match gated by block and pending transfers.
   assign cmp_event = tick & (count_r == compare_r) & ~block_r & ~(async_sel_r & (pend_r.cnt | pend_r.cmp));
   assign ovf_event = tick & (count_r == ATSI_COUNT_MAX);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_r <= ATSI_RST_BYTE;
      else if (wr_cnt & ~async_sel_r)
         count_r <= wbyte;
      else if (xfer.cnt)
         count_r <= count_tmp_r;
      else if (tick)
         count_r <= count_r + 8'h01;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         block_r <= 1'b0;
      else if ((wr_cnt & ~async_sel_r) | xfer.cnt)
         block_r <= 1'b1;
      else if (tick)
         block_r <= 1'b0;
   end

   chk_write_blocks_match: assert property ((wr_cnt && !async_sel_r) ##1 tick
      |=> $stable(compare_output_pin))
      else $error("compare match not suppressed after count write");
   chk_match_busy: assert property (async_sel_r && (pend_r.cnt || pend_r.cmp)
      |=> $stable(compare_output_pin))
      else $error("compare match during pending transfer");
   chk_sync_clock: assert property (!async_sel_r |-> tick == run)
      else $error("synchronous mode does not tick every cycle");

   // Refreshing one cycle after the rise picks up the count that the tick or a
   // transfer has just written, so a read made once busy clears is not stale.
   logic osc_rise_d_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_rise_d_r <= 1'b0;
         count_hold_r <= ATSI_RST_BYTE;
      end
      else
      begin
         osc_rise_d_r <= osc_rise;
         if (~async_sel_r | osc_rise_d_r)
            count_hold_r <= count_r;
      end
   end

   chk_hold_update: assert property (async_sel_r && !osc_rise_d_r |=> $stable(count_hold_r))
      else $error("holding register changed without oscillator edge");

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         compare_output_pin <= 1'b0;
      else if (cmp_event)
         compare_output_pin <= ~compare_output_pin;
   end

   // ********************************************************************
   // Interrupt flags and requests
   // ********************************************************************
   atsi_flags_t evt;
   atsi_flags_t fl_pend_r;
   atsi_flags_t fl_p0_r;
   atsi_flags_t fl_p1_r;
   atsi_flags_t fl_set;
   atsi_flags_t fl_clr;

   assign evt = {cmp_event, ovf_event};
   // Wait one tick, then the pclk stages.
   assign fl_set = async_sel_r ? fl_p1_r : evt;
   assign fl_clr = {compare_vector_ack | (wr_flag & wbyte[ATSI_CMP_FLAG_BIT]),
                    overflow_vector_ack | (wr_flag & wbyte[ATSI_OVF_FLAG_BIT])};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fl_pend_r <= '0;
         fl_p0_r <= '0;
         fl_p1_r <= '0;
      end
      else
      begin
         fl_pend_r <= ((fl_pend_r & ~{2{tick}}) | evt) & {2{async_sel_r}};
         fl_p0_r <= fl_pend_r & {2{tick}};
         fl_p1_r <= fl_p0_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_r <= '0;
      else
         flag_r <= (flag_r & ~fl_clr) | fl_set;
   end

   sequence s_async_pend_tick;
      async_sel_r && fl_pend_r.cmp && tick;
   endsequence
   sequence s_sel_held;
      async_sel_r [*2];
   endsequence
   chk_flag_delay: assert property (s_async_pend_tick ##1 s_sel_held |=> flag_r.cmp)
      else $error("async compare flag not set three cycles after tick");
   chk_flag_w1c: assert property (fl_clr.ovf && !fl_set.ovf |=> !flag_r.ovf)
      else $error("overflow flag not cleared");
   chk_cmp_set: assert property (!async_sel_r && cmp_event |=> flag_r.cmp)
      else $error("compare flag not set on match");

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         compare_irq <= 1'b0;
         overflow_irq <= 1'b0;
      end
      else
      begin
         compare_irq <= flag_r.cmp & irq_mask_r[ATSI_CMP_IE_BIT] & cpu_irq_enable;
         overflow_irq <= flag_r.ovf & irq_mask_r[ATSI_OVF_IE_BIT] & cpu_irq_enable;
      end
   end

   chk_irq_gate: assert property (compare_irq == $past(flag_r.cmp && irq_mask_r[1] && cpu_irq_enable))
      else $error("compare irq gating wrong");
   chk_ovf_irq: assert property (overflow_irq |-> $past(flag_r.ovf && irq_mask_r[0]))
      else $error("overflow irq without flag and enable");

   // ********************************************************************
   // Wake from power-save
   // ********************************************************************
   // Wake is only asserted after a further timer tick, so the counter has
   // advanced at least once before the CPU can read it.
   logic wake_pend_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_pend_r <= 1'b0;
         wake_req <= 1'b0;
      end
      else if (!power_save_sleep)
      begin
         wake_pend_r <= 1'b0;
         wake_req <= 1'b0;
      end
      else
      begin
         if (async_sel_r & (|evt))
            wake_pend_r <= 1'b1;
         if (wake_pend_r & tick)
            wake_req <= 1'b1;
      end
   end

   chk_wake_tick: assert property ($rose(wake_req) |-> $past(tick && wake_pend_r))
      else $error("wake without following tick");

endmodule : atsi_top

`default_nettype wire

// file: testbench/atsi_cpu_model.sv
// CPU side model: APB master that keeps the software duties of the timer.
`timescale 1ns/1ps
`default_nettype none
module atsi_cpu_model
   import atsi_pkg::*;
(
   input wire logic pclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   logic last_err;

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      last_err = 1'b0;
   end

   // *******************************************************************
   // Bus cycles
   // *******************************************************************
   // The request is held until pready is seen high, so a slow slave is safe.
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rdata = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [11:0] addr, input logic [31:0] data);
      logic [31:0] unused;
      xfer(1'b1, addr, data, unused);
   endtask : wr

   task automatic rd(input logic [11:0] addr, output logic [31:0] data);
      xfer(1'b0, addr, 32'h0000_0000, data);
   endtask : rd

   task automatic wait_idle();
      logic [31:0] st;
      int n;
      n = 0;
      st = 32'hFFFF_FFFF;
      while (st[2:0] !== 3'b000 && n < 200)
      begin
         rd(ATSI_OFF_ASYNC_STATUS, st);
         n++;
      end
   endtask : wait_idle

   task automatic switch_clock(input logic [31:0] status, input logic [7:0] cnt, input logic [7:0] cmp,
                               input logic [7:0] ctrl);
      wr(ATSI_OFF_IRQ_MASK, 32'h0000_0000);
      wr(ATSI_OFF_ASYNC_STATUS, status);
      wr(ATSI_OFF_COUNT, {24'h00_0000, cnt});
      wr(ATSI_OFF_COMPARE, {24'h00_0000, cmp});
      wr(ATSI_OFF_CONTROL, {24'h00_0000, ctrl});
      wait_idle();
      wr(ATSI_OFF_IRQ_FLAG, 32'h0000_0003);
   endtask : switch_clock
endmodule : atsi_cpu_model
`default_nettype wire

// file: testbench/atsi_top_test.sv
// Self-checking testbench for the asynchronous timer 0 block.
`timescale 1ns/1ps
`default_nettype none
module atsi_top_test
   import atsi_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv, c1;
   logic cpu_irq_enable, power_save_sleep, cmp_ack, ovf_ack;
   logic compare_irq, overflow_irq, compare_output_pin, wake_req, p0;
   logic [7:0] d;
   int num_errors, compares, n;

   atsi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_input_pin(osc), .cpu_irq_enable(cpu_irq_enable), .power_save_sleep(power_save_sleep),
      .compare_vector_ack(cmp_ack), .overflow_vector_ack(ovf_ack), .compare_irq(compare_irq),
      .overflow_irq(overflow_irq), .compare_output_pin(compare_output_pin), .wake_req(wake_req));
   atsi_cpu_model cpu (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // The crystal runs free at thirty pclk periods, its edges falling on pclk falling edges.
   initial
   begin
      osc = 1'b0;
      forever #75 osc = ~osc;
   end

   // *******************************************************************
   // Checking and reporting
   // *******************************************************************
   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check_word

   task automatic check_bit(input string what, input logic exp, input logic seen);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %b seen %b", what, exp, seen);
      end
   endtask : check_bit

   task automatic rd_check(input string what, input logic [11:0] addr, input logic [31:0] exp);
      cpu.rd(addr, rv);
      check_word(what, exp, rv);
   endtask : rd_check

   task automatic wait_flag(input int idx);
      n = 0;
      rv = 32'h0000_0000;
      while (rv[idx] !== 1'b1 && n < 400)
      begin
         cpu.rd(ATSI_OFF_IRQ_FLAG, rv);
         n++;
      end
   endtask : wait_flag

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize

   initial
   begin
      #200000;
      num_errors++;
      $display("watchdog expired");
      summarize();
   end

   // *******************************************************************
   // Tests
   // *******************************************************************
   initial
   begin
      presetn = 1'b0;
      cpu_irq_enable = 1'b0;
      power_save_sleep = 1'b0;
      cmp_ack = 1'b0;
      ovf_ack = 1'b0;
      num_errors = 0;
      compares = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++)
         rd_check("reset value", 12'(i * 4), 32'h0000_0000);
      cpu.wr(12'h018, 32'h0000_00FF);
      check_bit("write error", 1'b1, cpu.last_err);
      rd_check("unmapped read", 12'h018, 32'h0000_0000);
      check_bit("read error", 1'b1, cpu.last_err);
      $display("test reset done");

      cpu_irq_enable <= 1'b1;
      cpu.wr(ATSI_OFF_CONTROL, 32'h0000_0001);
      cpu.wr(ATSI_OFF_IRQ_MASK, 32'h0000_0002);
      cpu.wr(ATSI_OFF_COMPARE, 32'h0000_0080);
      cpu.wr(ATSI_OFF_IRQ_FLAG, 32'h0000_0003);
      p0 = compare_output_pin;
      wait_flag(ATSI_CMP_FLAG_BIT);
      check_bit("compare flag", 1'b1, rv[1]);
      check_bit("compare pin", ~p0, compare_output_pin);
      check_bit("compare irq", 1'b1, compare_irq);
      wait_flag(ATSI_OVF_FLAG_BIT);
      check_bit("overflow irq masked", 1'b0, overflow_irq);
      cpu.wr(ATSI_OFF_IRQ_MASK, 32'h0000_0003);
      repeat (2) @(posedge pclk);
      check_bit("overflow irq", 1'b1, overflow_irq);
      ovf_ack <= 1'b1;
      @(posedge pclk);
      ovf_ack <= 1'b0;
      cpu.rd(ATSI_OFF_IRQ_FLAG, rv);
      check_bit("overflow ack", 1'b0, rv[0]);
      cmp_ack <= 1'b1;
      @(posedge pclk);
      cmp_ack <= 1'b0;
      rd_check("compare ack", ATSI_OFF_IRQ_FLAG, 32'h0000_0000);
      cpu_irq_enable <= 1'b0;
      wait_flag(ATSI_CMP_FLAG_BIT);
      check_bit("irq gated", 1'b0, compare_irq);
      cpu.wr(ATSI_OFF_IRQ_FLAG, 32'h0000_0002);
      rd_check("write one clear", ATSI_OFF_IRQ_FLAG, 32'h0000_0000);
      cpu_irq_enable <= 1'b1;
      cpu.wr(ATSI_OFF_COUNT, 32'h0000_0010);
      cpu.wr(ATSI_OFF_IRQ_FLAG, 32'h0000_0003);
      cpu.wr(ATSI_OFF_COUNT, 32'h0000_0080);
      rd_check("match blocked", ATSI_OFF_IRQ_FLAG, 32'h0000_0000);
      $display("test sync done");

      repeat (60) @(posedge pclk);
      cpu.switch_clock(32'h0000_00FF, 8'h00, 8'h30, 8'h01);
      rd_check("async status", ATSI_OFF_ASYNC_STATUS, 32'h0000_0008);
      cpu.wr(ATSI_OFF_COUNT, 32'h0000_0040);
      cpu.rd(ATSI_OFF_ASYNC_STATUS, rv);
      check_bit("count busy", 1'b1, rv[2]);
      cpu.wr(ATSI_OFF_COMPARE, 32'h0000_0077);
      cpu.rd(ATSI_OFF_ASYNC_STATUS, rv);
      check_bit("compare busy", 1'b1, rv[1]);
      rd_check("compare temp", ATSI_OFF_COMPARE, 32'h0000_0077);
      cpu.wr(ATSI_OFF_CONTROL, 32'h0000_0001);
      cpu.rd(ATSI_OFF_ASYNC_STATUS, rv);
      check_bit("control busy", 1'b1, rv[0]);
      cpu.wait_idle();
      rd_check("busy cleared", ATSI_OFF_ASYNC_STATUS, 32'h0000_0008);
      cpu.rd(ATSI_OFF_COUNT, c1);
      d = c1[7:0] - 8'h40;
      check_bit("count landed", 1'b1, d <= 8'd3);
      cpu.rd(ATSI_OFF_COUNT, c1);
      repeat (600) @(posedge pclk);
      cpu.rd(ATSI_OFF_COUNT, rv);
      d = rv[7:0] - c1[7:0];
      check_bit("osc rate", 1'b1, d >= 8'd19 && d <= 8'd21);
      $display("test async done");

      cpu.wr(ATSI_OFF_IRQ_MASK, 32'h0000_0002);
      cpu.wr(ATSI_OFF_IRQ_FLAG, 32'h0000_0003);
      power_save_sleep <= 1'b1;
      n = 0;
      while (wake_req !== 1'b1 && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      check_bit("wake", 1'b1, wake_req);
      cpu.rd(ATSI_OFF_COUNT, rv);
      check_bit("advanced", 1'b1, rv[7:0] >= 8'h78 && rv[7:0] <= 8'h7A);
      cpu.rd(ATSI_OFF_IRQ_FLAG, rv);
      check_bit("async flag", 1'b1, rv[1]);
      check_bit("async irq", 1'b1, compare_irq);
      power_save_sleep <= 1'b0;
      repeat (3) @(posedge pclk);
      check_bit("wake drop", 1'b0, wake_req);
      $display("test wake done");
      summarize();
   end
endmodule : atsi_top_test
`default_nettype wire
